// ---- verilog/irqc_pkg.sv ----
// Package with offsets, reset values, vectors and types of the interrupt controller.
package irqc_pkg;

    // ****************************************
    // Register map and field positions
    // ****************************************
    localparam int          ADDR_W       = 8;
    localparam int          GRP_N        = 4;
    localparam int          GRP_W        = 8;
    localparam int          PC_W         = 21;
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_RESET    = 8'h04;
    localparam logic [7:0]  OFF_FLAG     = 8'h08;
    localparam logic [7:0]  OFF_EN       = 8'h18;
    localparam logic [7:0]  OFF_PRI      = 8'h28;
    localparam logic [7:0]  OFF_STATUS   = 8'h38;
    localparam logic [7:0]  GRP_SPAN     = 8'h10;
    localparam int          BIT_HIGH_EN  = 7;
    localparam int          BIT_LOW_EN   = 6;
    localparam int          BIT_PRIO_EN  = 7;

    // ****************************************
    // Reset values, vectors and bus answers
    // ****************************************
    localparam logic [7:0]      RST_BYTE    = 8'h00;
    localparam logic [7:0]      RST_PRI     = 8'hff;
    localparam logic [PC_W-1:0] VEC_HIGH    = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW     = 21'h000018;
    localparam logic [1:0]      RESP_OKAY   = 2'b00;
    localparam logic [1:0]      RESP_SLVERR = 2'b10;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic high;
        logic low;
    } lvl_t;

    typedef enum logic {ST_IDLE, ST_PEND} st_t;

endpackage

// ---- verilog/irq_ctrl.sv ----
// Two-level prioritised interrupt controller with AXI4-Lite register access.
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns

// Function
// - High requests vector to 0008h, low requests to 0018h under priority.
// - A pending high request pre-empts a running low handler.
// - Every source has flag, enable and priority select bits.
// - Two-level scheme works only while priority_scheme_enable is set.
// - With priority, high global enable admits all high-priority sources.
// - With priority, low sources need both high and low global enables.
// - Flag, enable and global enables set means immediate vectoring by priority.
// - With priority off, the default, priority selects have no effect.
// - Compatibility mode: bit 6 gates peripherals, bit 7 gates every source.
// - Compatibility mode: every accepted request vectors to 0008h.
// - Acceptance clears the global enable that admitted the request.
// - Low requests stay pending while a high handler runs.
// - Acceptance pushes the return address and loads the vector.
// - Return instruction leaves handler and restores the cleared enable.
// - External event to vectoring takes three cycles, fixed.
// - Flags set on events regardless of any enable.
module irq_ctrl #(
    parameter int STACK_D = 8
) (
    // Clock and reset.
    input  wire logic                       I_CLK,
    input  wire logic                       I_RESET_N,
    // AXI4-Lite write channels.
    input  wire logic                       I_AWVALID,
    output logic                            O_AWREADY,
    input  wire logic [irqc_pkg::ADDR_W-1:0] I_AWADDR,
    input  wire logic                       I_WVALID,
    output logic                            O_WREADY,
    input  wire logic [31:0]                I_WDATA,
    input  wire logic [3:0]                 I_WSTRB,
    output logic                            O_BVALID,
    input  wire logic                       I_BREADY,
    output logic [1:0]                      O_BRESP,
    // AXI4-Lite read channels.
    input  wire logic                       I_ARVALID,
    output logic                            O_ARREADY,
    input  wire logic [irqc_pkg::ADDR_W-1:0] I_ARADDR,
    output logic                            O_RVALID,
    input  wire logic                       I_RREADY,
    output logic [31:0]                     O_RDATA,
    output logic [1:0]                      O_RRESP,
    // Source events and core side.
    input  wire logic [31:0]                I_EVT,
    input  wire logic [irqc_pkg::PC_W-1:0]  I_RET_ADDR,
    input  wire logic                       I_RETURN_FROM_HANDLER_INSTR,
    output logic                            O_PC_LOAD,
    output logic [irqc_pkg::PC_W-1:0]       O_PC,
    output logic                            O_WAKE,
    output logic                            O_IN_HIGH,
    output logic                            O_IN_LOW
);

    localparam int SP_W = $clog2(STACK_D + 1);

    // ****************************************
    // State
    // ****************************************
    logic [3:0][7:0]            flag_q, flag_d, en_q, en_d, pri_q, pri_d;
    irqc_pkg::lvl_t             gen_q, gen_d, act_q, act_d;
    logic                       priority_scheme_enable_q, priority_scheme_enable_d;
    irqc_pkg::st_t              st_q, st_d;
    logic                       pend_hi_q, pend_hi_d, load_q, load_d;
    logic [irqc_pkg::PC_W-1:0]  pc_q, pc_d;
    logic [SP_W-1:0]            sp_q, sp_d;
    logic [irqc_pkg::PC_W-1:0]  stk_q [STACK_D];
    logic                       push;
    logic                       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]                 awa_q, awa_d;
    logic [7:0]                 wd_q, wd_d;
    logic                       ws_q, ws_d;
    logic [1:0]                 br_q, br_d, rr_q, rr_d;
    logic [31:0]                rd_q, rd_d;
    logic [31:0]                fe, hi_m, lo_m;
    logic                       req_hi, req_lo, do_wr;

    // ****************************************
    // Decode helpers
    // ****************************************
    // True when the address falls in a four-word group window.
    function automatic logic in_grp(input logic [7:0] a, input logic [7:0] base);
        in_grp = (a >= base) && (a < base + irqc_pkg::GRP_SPAN);
    endfunction

    // True for any implemented, word-aligned register address.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a == irqc_pkg::OFF_CTRL ||
                 a == irqc_pkg::OFF_RESET || a == irqc_pkg::OFF_STATUS ||
                 in_grp(a, irqc_pkg::OFF_FLAG) || in_grp(a, irqc_pkg::OFF_EN) ||
                 in_grp(a, irqc_pkg::OFF_PRI));
    endfunction

    // ****************************************
    // Request logic
    // ****************************************
    // Group 0 holds core sources (external pins, port change), groups 1..3 peripherals.
    always_comb begin
        fe   = flag_q & en_q;
        hi_m = fe & pri_q;
        lo_m = fe & ~pri_q;
        if (priority_scheme_enable_q) begin
            req_hi = gen_q.high && (|hi_m);
            req_lo = gen_q.high && gen_q.low && !act_q.high && (|lo_m);
        end else begin
            req_hi = gen_q.high && ((|fe[7:0]) || (gen_q.low && (|fe[31:8])));
            req_lo = 1'b0;
        end
    end

    // Wake-up ignores global enables so a sleeping core still restarts.
    assign O_WAKE = |fe;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Each channel holds one request at a time; a held response stalls new requests.
    assign O_AWREADY = !aw_q && !bv_q;
    assign O_WREADY  = !w_q && !bv_q;
    assign O_ARREADY = !rv_q;
    assign do_wr     = aw_q && w_q && !bv_q;

    always_comb begin
        aw_d  = aw_q;
        w_d   = w_q;
        awa_d = awa_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        rv_d  = rv_q;
        rr_d  = rr_q;
        rd_d  = rd_q;
        if (I_AWVALID && O_AWREADY) begin
            aw_d  = 1'b1;
            awa_d = I_AWADDR;
        end
        if (I_WVALID && O_WREADY) begin
            w_d  = 1'b1;
            wd_d = I_WDATA[7:0];
            ws_d = I_WSTRB[0];
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = mapped(awa_q) ? irqc_pkg::RESP_OKAY : irqc_pkg::RESP_SLVERR;
        end else if (bv_q && I_BREADY) begin
            bv_d = 1'b0;
        end
        if (I_ARVALID && O_ARREADY) begin
            rv_d = 1'b1;
            rr_d = mapped(I_ARADDR) ? irqc_pkg::RESP_OKAY : irqc_pkg::RESP_SLVERR;
            rd_d = 32'h00000000;
            if (I_ARADDR == irqc_pkg::OFF_CTRL) begin
                rd_d[7:6] = {gen_q.high, gen_q.low};
            end else if (I_ARADDR == irqc_pkg::OFF_RESET) begin
                rd_d[irqc_pkg::BIT_PRIO_EN] = priority_scheme_enable_q;
            end else if (I_ARADDR == irqc_pkg::OFF_STATUS) begin
                rd_d[15:0] = {act_q.high, act_q.low, pend_hi_q, st_q == irqc_pkg::ST_PEND,
                              4'(sp_q), 8'h00};
            end else if (mapped(I_ARADDR) && in_grp(I_ARADDR, irqc_pkg::OFF_FLAG)) begin
                rd_d[7:0] = flag_q[I_ARADDR[3:2] - 2'd2];
            end else if (mapped(I_ARADDR) && in_grp(I_ARADDR, irqc_pkg::OFF_EN)) begin
                rd_d[7:0] = en_q[I_ARADDR[3:2] - 2'd2];
            end else if (mapped(I_ARADDR) && in_grp(I_ARADDR, irqc_pkg::OFF_PRI)) begin
                rd_d[7:0] = pri_q[I_ARADDR[3:2] - 2'd2];
            end
        end else if (rv_q && I_RREADY) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aw_q  <= 1'b0;
            w_q   <= 1'b0;
            awa_q <= 8'h00;
            wd_q  <= 8'h00;
            ws_q  <= 1'b0;
            bv_q  <= 1'b0;
            br_q  <= 2'h0;
            rv_q  <= 1'b0;
            rr_q  <= 2'h0;
            rd_q  <= 32'h00000000;
        end else begin
            aw_q  <= aw_d;
            w_q   <= w_d;
            awa_q <= awa_d;
            wd_q  <= wd_d;
            ws_q  <= ws_d;
            bv_q  <= bv_d;
            br_q  <= br_d;
            rv_q  <= rv_d;
            rr_q  <= rr_d;
            rd_q  <= rd_d;
        end
    end

    assign O_BVALID = bv_q;
    assign O_BRESP  = br_q;
    assign O_RVALID = rv_q;
    assign O_RRESP  = rr_q;
    assign O_RDATA  = rd_q;

    // ****************************************
    // Controller sequence
    // ****************************************
    // Software writes land first; hardware sets and clears then override them.
    // The extra pend cycle fixes event-to-load latency at three edges.
    always_comb begin
        logic       wr;
        logic [1:0] g;
        wr        = do_wr && ws_q;
        g         = awa_q[3:2] - 2'd2;
        flag_d    = flag_q;
        en_d      = en_q;
        pri_d     = pri_q;
        gen_d     = gen_q;
        priority_scheme_enable_d    = priority_scheme_enable_q;
        act_d     = act_q;
        st_d      = st_q;
        pend_hi_d = pend_hi_q;
        load_d    = 1'b0;
        pc_d      = pc_q;
        sp_d      = sp_q;
        push      = 1'b0;
        if (wr && awa_q == irqc_pkg::OFF_CTRL) begin
            gen_d = {wd_q[irqc_pkg::BIT_HIGH_EN], wd_q[irqc_pkg::BIT_LOW_EN]};
        end
        if (wr && awa_q == irqc_pkg::OFF_RESET) begin
            priority_scheme_enable_d = wd_q[irqc_pkg::BIT_PRIO_EN];
        end
        if (wr && mapped(awa_q) && in_grp(awa_q, irqc_pkg::OFF_FLAG)) begin
            flag_d[g] = wd_q;
        end
        if (wr && mapped(awa_q) && in_grp(awa_q, irqc_pkg::OFF_EN)) begin
            en_d[g] = wd_q;
        end
        if (wr && mapped(awa_q) && in_grp(awa_q, irqc_pkg::OFF_PRI)) begin
            pri_d[g] = wd_q;
        end
        flag_d = flag_d | I_EVT;
        unique case (st_q)
            irqc_pkg::ST_IDLE: begin
                if (I_RETURN_FROM_HANDLER_INSTR) begin
                    load_d = 1'b1;
                    pc_d   = stk_q[sp_q[$clog2(STACK_D)-1:0] - 1'b1];
                    sp_d   = SP_W'(sp_q - 1'b1);
                    if (act_q.high) begin
                        act_d.high = 1'b0;
                        gen_d.high = 1'b1;
                    end else if (act_q.low) begin
                        act_d.low = 1'b0;
                        gen_d.low = 1'b1;
                    end
                end else if (req_hi || req_lo) begin
                    st_d      = irqc_pkg::ST_PEND;
                    pend_hi_d = req_hi;
                    if (req_hi) begin
                        gen_d.high = 1'b0;
                    end else begin
                        gen_d.low = 1'b0;
                    end
                end
            end
            irqc_pkg::ST_PEND: begin
                st_d   = irqc_pkg::ST_IDLE;
                load_d = 1'b1;
                push   = 1'b1;
                sp_d   = SP_W'(sp_q + 1'b1);
                pc_d   = pend_hi_q ? irqc_pkg::VEC_HIGH : irqc_pkg::VEC_LOW;
                if (pend_hi_q) begin
                    act_d.high = 1'b1;
                end else begin
                    act_d.low = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            flag_q    <= '0;
            en_q      <= '0;
            pri_q     <= {irqc_pkg::GRP_N{irqc_pkg::RST_PRI}};
            gen_q     <= '0;
            priority_scheme_enable_q    <= 1'b0;
            act_q     <= '0;
            st_q      <= irqc_pkg::ST_IDLE;
            pend_hi_q <= 1'b0;
            load_q    <= 1'b0;
            pc_q      <= '0;
            sp_q      <= '0;
        end else begin
            flag_q    <= flag_d;
            en_q      <= en_d;
            pri_q     <= pri_d;
            gen_q     <= gen_d;
            priority_scheme_enable_q    <= priority_scheme_enable_d;
            act_q     <= act_d;
            st_q      <= st_d;
            pend_hi_q <= pend_hi_d;
            load_q    <= load_d;
            pc_q      <= pc_d;
            sp_q      <= sp_d;
        end
    end

    // Return stack; overflow wraps silently, so nesting deeper than STACK_D is lost.
    always_ff @(posedge I_CLK) begin
        if (push) begin
            stk_q[sp_q[$clog2(STACK_D)-1:0]] <= I_RET_ADDR;
        end
    end

    assign O_PC_LOAD = load_q;
    assign O_PC      = pc_q;
    assign O_IN_HIGH = act_q.high;
    assign O_IN_LOW  = act_q.low;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    property p_vec_high;
        st_q == irqc_pkg::ST_PEND && pend_hi_q && priority_scheme_enable_q |=> load_q && pc_q == 21'h000008;
    endproperty
    a_vec_high: assert property (p_vec_high) else $error("high vector wrong");

    property p_vec_low;
        st_q == irqc_pkg::ST_PEND && !pend_hi_q |=> load_q && pc_q == 21'h000018;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("low vector wrong");

    property p_compat_single;
        st_q == irqc_pkg::ST_PEND && !priority_scheme_enable_q |-> pend_hi_q;
    endproperty
    a_compat_single: assert property (p_compat_single) else $error("compat low vector");

    property p_latency;
        st_q == irqc_pkg::ST_IDLE && (req_hi || req_lo) && !I_RETURN_FROM_HANDLER_INSTR
            |=> st_q == irqc_pkg::ST_PEND ##1 load_q;
    endproperty
    a_latency: assert property (p_latency) else $error("vectoring latency off");

    property p_clear_high;
        st_q == irqc_pkg::ST_IDLE && req_hi && !I_RETURN_FROM_HANDLER_INSTR |=> !gen_q.high;
    endproperty
    a_clear_high: assert property (p_clear_high) else $error("enable not cleared");

    property p_hold_low;
        act_q.high |-> !req_lo;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("low served in high");

    property p_no_prio;
        !priority_scheme_enable_q |-> !req_lo;
    endproperty
    a_no_prio: assert property (p_no_prio) else $error("priority used when off");

    property p_flag_set;
        I_EVT[8] |=> flag_q[1][0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_push;
        st_q == irqc_pkg::ST_PEND |=> sp_q == SP_W'($past(sp_q) + 1'b1);
    endproperty
    a_push: assert property (p_push) else $error("no stack push");

    property p_return;
        I_RETURN_FROM_HANDLER_INSTR && st_q == irqc_pkg::ST_IDLE && act_q.high |=> gen_q.high && !act_q.high;
    endproperty
    a_return: assert property (p_return) else $error("return did not restore");

    c_high: cover property (load_q && act_q.high && !act_q.low);
    c_low: cover property (load_q && act_q.low && !act_q.high);
    c_preempt: cover property (load_q && act_q.low && act_q.high);
    c_ret: cover property (I_RETURN_FROM_HANDLER_INSTR && act_q.low);

endmodule // irq_ctrl

// ---- test/core_model.sv ----
// Behavioural model of the processor core that takes vectors and executes returns.
`timescale 1ns/1ns
module core_model (
    // Clock and reset.
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    // Program counter loads from the controller.
    input  wire logic                      i_pc_load,
    input  wire logic [irqc_pkg::PC_W-1:0] i_pc,
    // Firmware commands from the bench.
    input  wire logic                      i_step,
    input  wire logic                      i_ret_req,
    input  wire logic [3:0]                i_ret_wait,
    // Core outputs to the controller.
    output logic [irqc_pkg::PC_W-1:0]      o_ret_addr,
    output logic                           o_return_from_handler_instr
);
    logic [3:0] wait_q;
    logic       armed_q;

    // The counter moves only on a step or a load, so the pushed address is always known.
    // The model never writes controller registers, least of all by memory-to-memory moves.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ret_addr <= 21'h000100;
            o_return_from_handler_instr   <= 1'b0;
            armed_q    <= 1'b0;
            wait_q     <= 4'h0;
        end else begin
            o_return_from_handler_instr <= 1'b0;
            if (i_pc_load) begin
                o_ret_addr <= i_pc;
            end else if (i_step) begin
                o_ret_addr <= o_ret_addr + 21'h000002;
            end
            // A return goes out as one pulse, promptly or some cycles late.
            if (i_ret_req) begin
                armed_q <= 1'b1;
                wait_q  <= i_ret_wait;
            end else if (armed_q && wait_q == 4'h0) begin
                armed_q  <= 1'b0;
                o_return_from_handler_instr <= 1'b1;
            end else if (armed_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule // core_model

// ---- test/two_level_interrupt_controller_tb.sv ----
// Self-checking testbench of the two-level interrupt controller with a core model.
`timescale 1ns/1ns
module two_level_interrupt_controller_tb;
    localparam logic [1:0] rsp_ok  = irqc_pkg::RESP_OKAY;
    localparam logic [1:0] rsp_err = irqc_pkg::RESP_SLVERR;

    // ****************************************
    // Signals, design and core model
    // ****************************************
    logic                      clk = 1'b0, reset_n = 1'b0, step = 1'b0, ret_req = 1'b0;
    logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                      arvalid = 1'b0, rready = 1'b0;
    logic [7:0]                awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]               wdata = 32'h0, evt = 32'h0, rdata;
    logic [3:0]                wstrb = 4'h1, ret_wait = 4'h0;
    logic                      awready, wready, bvalid, arready, rvalid, return_from_handler_instr;
    logic                      pc_load, wake, in_high, in_low;
    logic [1:0]                bresp, rresp;
    logic [irqc_pkg::PC_W-1:0] pc, ret_addr;
    logic [irqc_pkg::PC_W-1:0] stk[$];
    int                        err_count = 0;
    int                        samples_checked = 0;

    irq_ctrl i_dut (
        .I_CLK(clk), .I_RESET_N(reset_n),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
        .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
        .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
        .I_EVT(evt), .I_RET_ADDR(ret_addr), .I_RETURN_FROM_HANDLER_INSTR(return_from_handler_instr), .O_PC_LOAD(pc_load),
        .O_PC(pc), .O_WAKE(wake), .O_IN_HIGH(in_high), .O_IN_LOW(in_low)
    );

    core_model i_core (
        .i_clk(clk), .i_reset_n(reset_n), .i_pc_load(pc_load), .i_pc(pc), .i_step(step),
        .i_ret_req(ret_req), .i_ret_wait(ret_wait), .o_ret_addr(ret_addr), .o_return_from_handler_instr(return_from_handler_instr)
    );

    // A 50 ns clock, and a watchdog sized well above the three passes of the run.
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        tally_and_finish();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One bus access; handshakes are judged at the falling edge so no edge race arises.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] rsp);
        logic da, dw, dr, ta, tw, tr;
        logic [31:0] got;
        logic [1:0] r;
        @(posedge clk);
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h0, d};
        da = 1'b0;
        dw = !w;
        dr = 1'b0;
        while (!(da && dw && dr)) begin
            @(negedge clk);
            ta = (awvalid && awready) || (arvalid && arready);
            tw = wvalid && wready;
            tr = (bready && bvalid) || (rready && rvalid);
            got = rdata;
            r = w ? bresp : rresp;
            @(posedge clk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
                da = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                dw = 1'b1;
            end
            if (tr) begin
                bready <= 1'b0;
                rready <= 1'b0;
                dr = 1'b1;
            end
        end
        chk("response", rsp, r);
        if (!w && rsp == rsp_ok) chk("read_data", {24'h0, d}, got);
    endtask

    // Pulses one source, or none, and counts edges until a program counter load shows.
    task automatic catch_load(input int idx, output int n);
        n = 0;
        for (int k = 0; k < 12 && n == 0; k++) begin
            @(posedge clk);
            evt <= (k == 0 && idx >= 0) ? (32'h1 << idx) : 32'h0;
            ret_req <= 1'b0;
            #1;
            if (pc_load === 1'b1) n = k;
        end
    endtask

    task automatic take(input int idx, input logic [20:0] vec, input logic [1:0] lv,
                        input logic [7:0] ce);
        int n;
        @(negedge clk);
        catch_load(idx, n);
        // The core takes the load one edge late, so it still shows the pushed address.
        stk.push_back(ret_addr);
        if (idx >= 0) chk("latency", 1, 32'(n >= 3 && n <= 4));
        chk("vector", vec, pc);
        chk("level", lv, {in_high, in_low});
        bus(0, 8'h00, ce, rsp_ok);
    endtask

    task automatic leave(input int idx);
        int n;
        bus(1, 8'(8 + 4 * (idx / 8)), 8'h00, rsp_ok);
        ret_wait <= 4'($urandom_range(3));
        ret_req <= 1'b1;
        catch_load(-1, n);
        chk("return_pc", stk.pop_back(), pc);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int n, b0, p, p2;
        void'($urandom(51));
        repeat (3) begin
            // Each pass resets, the later ones in mid-run, then reads the reset state.
            reset_n <= 1'b0;
            repeat (4) @(posedge clk);
            reset_n <= 1'b1;
            for (int g = 0; g < 4; g++) begin
                bus(0, 8'(8 + 4 * g), 8'h00, rsp_ok);
                bus(0, 8'(24 + 4 * g), 8'h00, rsp_ok);
                bus(0, 8'(40 + 4 * g), 8'hff, rsp_ok);
            end
            bus(0, 8'h04, 8'h00, rsp_ok);
            bus(0, 8'h38, 8'h00, rsp_ok);
            bus(0, 8'h3c, 8'h00, rsp_err);
            bus(1, 8'h41, 8'h55, rsp_err);
            b0 = $urandom_range(7);
            p = 8 + $urandom_range(7);
            p2 = 16 + 8 * $urandom_range(1) + $urandom_range(7);
            // Flags can be polled and wake-up needs no global enable.
            catch_load(p, n);
            chk("vector_count", 0, n);
            bus(0, 8'h0c, 8'(1 << (p - 8)), rsp_ok);
            chk("wake", 0, wake);
            bus(1, 8'h1c, 8'(1 << (p - 8)), rsp_ok);
            chk("wake", 1, wake);
            bus(1, 8'h0c, 8'h00, rsp_ok);
            chk("wake", 0, wake);
            bus(1, 8'h18, 8'(1 << b0), rsp_ok);
            bus(1, 8'(24 + 4 * (p2 / 8)), 8'(1 << (p2 % 8)), rsp_ok);
            bus(1, 8'h2c, ~8'(1 << (p - 8)), rsp_ok);
            bus(1, 8'(40 + 4 * (p2 / 8)), ~8'(1 << (p2 % 8)), rsp_ok);
            // Compatibility mode, where bit 7 alone admits only the core sources.
            bus(1, 8'h00, 8'h80, rsp_ok);
            catch_load(p, n);
            chk("vector_count", 0, n);
            bus(1, 8'h0c, 8'h00, rsp_ok);
            take(b0, irqc_pkg::VEC_HIGH, 2'b10, 8'h00);
            leave(b0);
            bus(0, 8'h00, 8'h80, rsp_ok);
            bus(1, 8'h00, 8'hc0, rsp_ok);
            take(p, irqc_pkg::VEC_HIGH, 2'b10, 8'h40);
            leave(p);
            bus(0, 8'h00, 8'hc0, rsp_ok);
            // Priority mode; handlers leave the cleared enables alone.
            bus(1, 8'h04, 8'h80, rsp_ok);
            bus(0, 8'h04, 8'h80, rsp_ok);
            bus(1, 8'h00, 8'h80, rsp_ok);
            catch_load(p, n);
            chk("vector_count", 0, n);
            bus(1, 8'h0c, 8'h00, rsp_ok);
            take(b0, irqc_pkg::VEC_HIGH, 2'b10, 8'h00);
            leave(b0);
            bus(0, 8'h00, 8'h80, rsp_ok);
            bus(1, 8'h00, 8'hc0, rsp_ok);
            take(p, irqc_pkg::VEC_LOW, 2'b01, 8'h80);
            @(posedge clk);
            step <= 1'b1;
            repeat ($urandom_range(5, 1)) @(posedge clk);
            step <= 1'b0;
            take(b0, irqc_pkg::VEC_HIGH, 2'b11, 8'h00);
            catch_load(p2, n);
            chk("vector_count", 0, n);
            leave(b0);
            bus(0, 8'h00, 8'h80, rsp_ok);
            leave(p);
            take(-1, irqc_pkg::VEC_LOW, 2'b01, 8'h80);
            leave(p2);
            bus(0, 8'h00, 8'hc0, rsp_ok);
        end
        tally_and_finish();
    end
endmodule // two_level_interrupt_controller_tb
